//--- shared/adp_pkg.sv
// constants and an index-to-address helper for the address/data shared i/o ports
package adp_pkg;
  // printed offsets are not multiples of four: they are register indices
  localparam logic [15:0] IDX_ADDR_DIR    = 16'hfebb;
  localparam logic [15:0] IDX_DATA_DIR    = 16'hfebc;
  localparam logic [15:0] IDX_ADDR_PIN    = 16'hff5b;
  localparam logic [15:0] IDX_DATA_PIN    = 16'hff5c;
  localparam logic [15:0] IDX_ADDR_OUT    = 16'hff6b;
  localparam logic [15:0] IDX_DATA_OUT    = 16'hff6c;
  localparam logic [15:0] IDX_ADDR_PULL   = 16'hff72;
  localparam logic [15:0] IDX_DATA_PULL   = 16'hff73;
  localparam logic [15:0] IDX_STBY_CTRL   = 16'hff80;
  localparam logic [15:0] IDX_STATUS      = 16'hff81;
  localparam int          ADDR_W          = 18;
  localparam logic [7:0]  RST_PORT        = 8'h00;
  localparam logic [7:0]  DIR_READ_VALUE  = 8'hff;
  localparam int          STBY_HOLD_BIT   = 0;
  localparam int          STBY_SOFT_BIT   = 1;
  localparam int          ST_MODE_LSB     = 0;
  localparam int          ST_STBY_BIT     = 3;
  localparam int          ST_HWSTBY_BIT   = 4;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 18'h3fffc;

  function automatic logic [ADDR_W-1:0] adp_byte_addr(input logic [15:0] idx);
    adp_byte_addr = {idx, 2'b00};
  endfunction
endpackage

//--- logic/adp_io_ports.sv
// two 8-bit shared address/data gpio ports with apb register access
// Operation
// RL1: direction registers write-only, read undefined
// RL2: software writes direction registers whole only
// RL3: registers clear on power-on, hardware standby
// RL4: modes 1,4,5 address port drives address
// RL5: modes 2,6 direction picks address or input
// RL6: modes 3,7 address port plain gpio
// RL7: modes 1,2,4,5,6 data port is bus
// RL8: modes 3,7 data port plain gpio
// RL9: output value register reads back written
// RL10: pin-state register read-only, writes ignored
// RL11: pin-state reads out value or pin
// RL12: pin-state kept across manual reset, standby
// RL13: address pull-up modes 2,3,6,7 input only
// RL14: data pull-up modes 3,7 input only
// RL15: pull-ups off while pins serve bus
// RL16: pull-ups off at power-on, hardware standby
// RL17: standby hold bit: keep address or float
// RL18: writes reach pins next clock edge
// RL19: bus modes use bus controller signals
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adp_io_ports (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      hwStandby,
  input  wire logic [2:0]                opMode,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [adp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [7:0]                busAddr,
  input  wire logic [7:0]                busDataOut,
  input  wire logic                      busDataDrive,
  output logic      [7:0]                busDataIn,
  input  wire logic [7:0]                addrPinIn,
  output logic      [7:0]                addrPinOut,
  output logic      [7:0]                addrPinOe,
  output logic      [7:0]                addrPullup,
  input  wire logic [7:0]                dataPinIn,
  output logic      [7:0]                dataPinOut,
  output logic      [7:0]                dataPinOe,
  output logic      [7:0]                dataPullup
);
  import adp_pkg::*;

  logic [7:0] addrDir_ff, dataDir_ff, addrOut_ff, dataOut_ff;
  logic [7:0] addrPull_ff, dataPull_ff;
  logic [1:0] stby_ff;
  logic [7:0] addrSync1_ff, addrSync_ff, dataSync1_ff, dataSync_ff;
  logic       hwSync1_ff, hwSync_ff;
  logic [7:0] addrPinReg_ff, dataPinReg_ff;
  logic [7:0] addrHeld_ff;
  logic       stbyPrev_ff;

  // mode decode
  function automatic logic addr_forced(input logic [2:0] m);
    addr_forced = (m == 3'd1) || (m == 3'd4) || (m == 3'd5);
  endfunction
  function automatic logic addr_bus_sel(input logic [2:0] m);
    addr_bus_sel = (m == 3'd2) || (m == 3'd6);
  endfunction
  function automatic logic data_is_bus(input logic [2:0] m);
    data_is_bus = (m == 3'd1) || (m == 3'd2) || (m == 3'd4) || (m == 3'd5) || (m == 3'd6);
  endfunction
  function automatic logic gpio_mode(input logic [2:0] m);
    gpio_mode = (m == 3'd3) || (m == 3'd7);
  endfunction

  // pin-state view: output value where driven, pin level elsewhere
  function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] outv,
                                          input logic [7:0] pin);
    pin_view = (dir & outv) | (~dir & pin);
  endfunction

  logic wrEn, rdEn, hwClr, softStby, wrOk;
  logic [15:0] regIdx;
  logic [7:0]  addrRd, dataRd, wByte, statusRd;
  logic        idxHit;
  // a write lands at the edge that completes the transfer
  assign wrEn     = psel && penable && pwrite && pready;
  assign rdEn     = psel && penable && !pwrite && !pready;
  assign regIdx   = paddr[ADDR_W-1:2];
  assign wByte    = pwdata[7:0];
  assign hwClr    = hwSync_ff;
  assign softStby = stby_ff[STBY_SOFT_BIT];
  // no register sits behind pin-state or status indices
  assign wrOk     = wrEn && pstrb[0]; // RL10

  // address pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrSync1_ff <= RST_PORT;
      addrSync_ff  <= RST_PORT;
    end else begin
      addrSync1_ff <= addrPinIn;
      addrSync_ff  <= addrSync1_ff;
    end
  end

  // data pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataSync1_ff <= RST_PORT;
      dataSync_ff  <= RST_PORT;
    end else begin
      dataSync1_ff <= dataPinIn;
      dataSync_ff  <= dataSync1_ff;
    end
  end

  // hardware standby synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hwSync1_ff <= 1'b0;
      hwSync_ff  <= 1'b0;
    end else begin
      hwSync1_ff <= hwStandby;
      hwSync_ff  <= hwSync1_ff;
    end
  end

  // port registers; rst_n is the power-on reset, manual reset does not reach here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrDir_ff <= RST_PORT; // RL3
    end else if (hwClr) begin
      addrDir_ff <= RST_PORT; // RL3
    end else if (wrOk && regIdx == IDX_ADDR_DIR) begin
      addrDir_ff <= wByte;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataDir_ff <= RST_PORT; // RL3
    end else if (hwClr) begin
      dataDir_ff <= RST_PORT; // RL3
    end else if (wrOk && regIdx == IDX_DATA_DIR) begin
      dataDir_ff <= wByte;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrOut_ff <= RST_PORT; // RL3
    end else if (hwClr) begin
      addrOut_ff <= RST_PORT; // RL3
    end else if (wrOk && regIdx == IDX_ADDR_OUT) begin
      addrOut_ff <= wByte; // RL9
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut_ff <= RST_PORT; // RL3
    end else if (hwClr) begin
      dataOut_ff <= RST_PORT; // RL3
    end else if (wrOk && regIdx == IDX_DATA_OUT) begin
      dataOut_ff <= wByte; // RL9
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrPull_ff <= RST_PORT; // RL16
    end else if (hwClr) begin
      addrPull_ff <= RST_PORT; // RL16
    end else if (wrOk && regIdx == IDX_ADDR_PULL) begin
      addrPull_ff <= wByte;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPull_ff <= RST_PORT; // RL16
    end else if (hwClr) begin
      dataPull_ff <= RST_PORT; // RL16
    end else if (wrOk && regIdx == IDX_DATA_PULL) begin
      dataPull_ff <= wByte;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stby_ff <= 2'b00;
    end else if (hwClr) begin
      stby_ff <= 2'b00;
    end else if (wrOk && regIdx == IDX_STBY_CTRL) begin
      stby_ff <= wByte[1:0];
    end
  end

  // pin-state views, registered so they hold through software standby
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrPinReg_ff <= RST_PORT;
    end else if (!softStby) begin
      addrPinReg_ff <= pin_view(addrDir_ff, addrOut_ff, addrSync_ff); // RL11
    end else begin
      addrPinReg_ff <= addrPinReg_ff; // RL12
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPinReg_ff <= RST_PORT;
    end else if (!softStby) begin
      dataPinReg_ff <= pin_view(dataDir_ff, dataOut_ff, dataSync_ff); // RL11
    end else begin
      dataPinReg_ff <= dataPinReg_ff; // RL12
    end
  end

  // standby entry detect
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stbyPrev_ff <= 1'b0;
    end else begin
      stbyPrev_ff <= softStby;
    end
  end

  // driven address level captured on standby entry for the hold option
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrHeld_ff <= RST_PORT;
    end else if (softStby && !stbyPrev_ff) begin
      addrHeld_ff <= addrPinOut; // RL17
    end
  end

  // pin drive, next edge after a register write
  logic [7:0] nxt_addrOut, nxt_addrOe, nxt_addrPull;
  logic [7:0] nxt_dataOut, nxt_dataOe, nxt_dataPull;
  logic [7:0] addrSrc;
  always_comb begin
    // entry cycle keeps the level on the pins, later cycles the captured copy
    addrSrc      = softStby ? (stbyPrev_ff ? addrHeld_ff : addrPinOut) : busAddr;
    nxt_addrOut  = RST_PORT;
    nxt_addrOe   = RST_PORT;
    nxt_addrPull = RST_PORT; // RL15
    if (addr_forced(opMode)) begin
      nxt_addrOut = addrSrc; // RL19
      nxt_addrOe  = 8'hff; // RL4
    end else if (addr_bus_sel(opMode)) begin
      nxt_addrOut  = addrSrc & addrDir_ff;
      nxt_addrOe   = addrDir_ff; // RL5
      nxt_addrPull = ~addrDir_ff & addrPull_ff; // RL13
    end else if (gpio_mode(opMode)) begin
      nxt_addrOut  = addrOut_ff & addrDir_ff;
      nxt_addrOe   = addrDir_ff; // RL6
      nxt_addrPull = ~addrDir_ff & addrPull_ff; // RL13
    end
    // standby float when hold bit clear, bus modes only
    if (softStby && !stby_ff[STBY_HOLD_BIT] && !gpio_mode(opMode)) begin
      nxt_addrOe = RST_PORT; // RL17
      nxt_addrOut = RST_PORT;
    end
  end

  // data port pin function
  always_comb begin
    nxt_dataOut  = RST_PORT;
    nxt_dataOe   = RST_PORT;
    nxt_dataPull = RST_PORT; // RL15
    if (data_is_bus(opMode)) begin
      nxt_dataOut = busDataDrive ? busDataOut : RST_PORT; // RL7
      nxt_dataOe  = busDataDrive ? 8'hff : RST_PORT; // RL19
    end else if (gpio_mode(opMode)) begin
      nxt_dataOut  = dataOut_ff & dataDir_ff;
      nxt_dataOe   = dataDir_ff; // RL8
      nxt_dataPull = ~dataDir_ff & dataPull_ff; // RL14
    end
  end

  // address port pin registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrPinOut <= RST_PORT;
      addrPinOe  <= RST_PORT;
      addrPullup <= RST_PORT; // RL16
    end else begin
      addrPinOut <= nxt_addrOut; // RL18
      addrPinOe  <= nxt_addrOe;
      addrPullup <= nxt_addrPull;
    end
  end

  // data port pin registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPinOut <= RST_PORT;
      dataPinOe  <= RST_PORT;
      dataPullup <= RST_PORT; // RL16
    end else begin
      dataPinOut <= nxt_dataOut; // RL18
      dataPinOe  <= nxt_dataOe;
      dataPullup <= nxt_dataPull;
    end
  end

  // data pins handed to the bus controller
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busDataIn <= RST_PORT;
    end else begin
      busDataIn <= data_is_bus(opMode) ? dataSync_ff : RST_PORT; // RL19
    end
  end

  // status word
  always_comb begin
    statusRd                   = RST_PORT;
    statusRd[ST_MODE_LSB +: 3] = opMode;
    statusRd[ST_STBY_BIT]      = softStby;
    statusRd[ST_HWSTBY_BIT]    = hwSync_ff;
  end

  // apb read mux
  always_comb begin
    idxHit = 1'b1;
    addrRd = RST_PORT;
    dataRd = RST_PORT;
    case (regIdx)
      IDX_ADDR_DIR:  addrRd = DIR_READ_VALUE; // RL1
      IDX_DATA_DIR:  addrRd = DIR_READ_VALUE;
      IDX_ADDR_OUT:  addrRd = addrOut_ff; // RL9
      IDX_DATA_OUT:  addrRd = dataOut_ff;
      IDX_ADDR_PIN:  addrRd = addrPinReg_ff;
      IDX_DATA_PIN:  addrRd = dataPinReg_ff;
      IDX_ADDR_PULL: addrRd = addrPull_ff;
      IDX_DATA_PULL: addrRd = dataPull_ff;
      IDX_STBY_CTRL: addrRd = {6'h00, stby_ff};
      IDX_STATUS:    addrRd = statusRd;
      default:       idxHit = 1'b0;
    endcase
    dataRd = addrRd;
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // unmapped index answered with an error beside pready
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !idxHit;
    end
  end

  // read data stands beside pready, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (rdEn && idxHit) ? {24'h00_0000, dataRd} : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

//--- verif/adp_pin_model.sv
// far side of the port pins: pull-ups, else an outside level
`timescale 1ns/1ps
`default_nettype none
module adp_pin_model (
  input  wire logic [15:0] outV,
  input  wire logic [15:0] oe,
  input  wire logic [15:0] pull,
  input  wire logic [15:0] ext,
  output logic      [15:0] pinIn
);
  // driven bits win, then the pull-up, then the outside level
  assign pinIn = (oe & outV) | (~oe & (pull | ext));
endmodule
`default_nettype wire

//--- verif/adp_io_ports_monitor.sv
// checker: pin function, pull-ups and apb answer of the shared ports
`timescale 1ns/1ps
`default_nettype none
module adp_io_ports_monitor (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [2:0] opMode,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [7:0] busDataOut,
  input wire logic       busDataDrive,
  input wire logic [7:0] addrPinOe,
  input wire logic [7:0] addrPullup,
  input wire logic [7:0] dataPinOut,
  input wire logic [7:0] dataPinOe,
  input wire logic [7:0] dataPullup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire gp = opMode == 3'd3 || opMode == 3'd7;
  wire fa = opMode == 3'd1 || opMode == 3'd4 || opMode == 3'd5;
  wire bm = !gp && opMode != 3'd0;
  addr_bus_pull_a: assert property (fa |-> addrPullup == 8'h00)
    else $error("address pull-up in bus mode");
  data_bus_pull_a: assert property (!gp |-> dataPullup == 8'h00)
    else $error("data pull-up in bus mode");
  pull_input_a: assert property (((addrPullup & addrPinOe) | (dataPullup & dataPinOe)) == 0)
    else $error("pull-up on a driven pin");
  data_drive_a: assert property (bm && busDataDrive ##1 busDataDrive && $stable(busDataOut)
    |-> dataPinOe == 8'hff && dataPinOut == busDataOut)
    else $error("data bus not driven");
  data_float_a: assert property (bm && !busDataDrive ##1 !busDataDrive |-> dataPinOe == 0)
    else $error("data bus driven when idle");
  ready_time_a: assert property ($rose(penable) && psel |=> pready)
    else $error("late ready");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready not a pulse");
  rst_clear_a: assert property ($rose(rst_n) |-> (addrPinOe | addrPullup | dataPullup) == 0)
    else $error("pins active after reset");
  cover property (fa && addrPinOe == 8'hff);
  cover property (bm && dataPinOe == 8'hff);
  cover property (gp && dataPullup != 8'h00);
endmodule
bind adp_io_ports adp_io_ports_monitor adp_io_ports_monitor_i (.sys_clk, .rst_n, .opMode, .psel,
  .penable, .pready, .busDataOut, .busDataDrive, .addrPinOe, .addrPullup, .dataPinOut,
  .dataPinOe, .dataPullup);
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the shared address/data ports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adp_pkg::*;
  logic              sys_clk = 0, rst_n = 0, hwStandby = 0, psel = 0, penable = 0;
  logic              pwrite = 0, busDataDrive = 0, pready, pslverr, err, g, f;
  logic [2:0]        opMode = 3'd3;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata;
  logic [7:0]        busAddr = 8'hc3, busDataOut = 8'h96, extA = 8'h6c, extD = 8'h5b, q;
  logic [7:0]        busDataIn, addrPinOut, addrPinOe, addrPullup;
  logic [7:0]        dataPinOut, dataPinOe, dataPullup;
  wire  [15:0]       pins;
  int                n_fail = 0, total_checks = 0;
  adp_io_ports adp_io_ports_i (.sys_clk, .rst_n, .hwStandby, .opMode, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'h1), .prdata, .pready, .pslverr, .busAddr, .busDataOut,
    .busDataDrive, .busDataIn, .addrPinIn(pins[7:0]), .addrPinOut, .addrPinOe, .addrPullup,
    .dataPinIn(pins[15:8]), .dataPinOut, .dataPinOe, .dataPullup);
  adp_pin_model adp_pin_model_i (.outV({dataPinOut, addrPinOut}), .oe({dataPinOe, addrPinOe}),
    .pull({dataPullup, addrPullup}), .ext({extD, extA}), .pinIn(pins));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 9 && pready !== 1'b1; k++) @(posedge sys_clk);
    if (k == 9) begin
      n_fail++;
      summarize();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic restart(input logic [2:0] m);
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    opMode <= m;
    rst_n <= 1'b1;
  endtask
  task automatic t_regs();
    restart(3'd3);
    xfer(0, IDX_DATA_PULL, 0);
    chk(q, RST_PORT);
    xfer(0, IDX_ADDR_DIR, 0);
    chk(q, DIR_READ_VALUE);
    xfer(1, IDX_ADDR_PIN, 8'hff);
    xfer(0, IDX_ADDR_PIN, 0);
    chk(q, extA);
    xfer(0, IDX_ADDR_OUT, 0);
    chk(q, RST_PORT);
    xfer(0, 16'h0100, 0);
    chk({7'h0, err}, 8'h01);
    $display("register test done");
  endtask
  task automatic t_modes();
    for (int m = 1; m < 8; m++) begin
      restart(m[2:0]);
      g = m == 3 || m == 7;
      f = m == 1 || m == 4 || m == 5;
      xfer(1, IDX_ADDR_DIR, 8'h0f);
      xfer(1, IDX_DATA_DIR, 8'h33);
      xfer(1, IDX_ADDR_OUT, 8'h5a);
      xfer(1, IDX_DATA_OUT, 8'hc6);
      xfer(1, IDX_ADDR_PULL, 8'h30);
      xfer(1, IDX_DATA_PULL, 8'h44);
      busDataDrive <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(addrPinOe, f ? 8'hff : 8'h0f);
      chk(addrPinOut & (f ? 8'hff : 8'h0f), g ? 8'h0a : busAddr & (f ? 8'hff : 8'h0f));
      chk(addrPullup, f ? 8'h00 : 8'h30);
      chk(dataPinOe, g ? 8'h33 : 8'hff);
      chk(dataPinOut & (g ? 8'h33 : 8'hff), g ? 8'h02 : busDataOut);
      chk(dataPullup, g ? 8'h44 : 8'h00);
      busDataDrive <= 1'b0;
      xfer(0, IDX_DATA_OUT, 0);
      chk(q, 8'hc6);
      repeat (4) @(posedge sys_clk);
      chk(busDataIn, g ? 8'h00 : extD);
      xfer(0, IDX_ADDR_PIN, 0);
      chk(q, 8'h0a | (8'hf0 & (f ? busAddr : (8'h30 | extA))));
    end
    $display("mode test done");
  endtask
  task automatic t_stby();
    restart(3'd2);
    busAddr <= 8'h81;
    xfer(1, IDX_ADDR_DIR, 8'h0f);
    xfer(1, IDX_ADDR_PULL, 8'hf0);
    xfer(1, IDX_STBY_CTRL, 8'h03);
    busAddr <= 8'h18;
    repeat (3) @(posedge sys_clk);
    chk(addrPinOut & 8'h0f, 8'h01);
    chk(addrPullup, 8'hf0);
    xfer(1, IDX_STBY_CTRL, 8'h00);
    xfer(1, IDX_STBY_CTRL, 8'h02);
    repeat (3) @(posedge sys_clk);
    chk(addrPinOe, 8'h00);
    xfer(0, IDX_ADDR_PULL, 0);
    chk(q, 8'hf0);
    hwStandby <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(addrPullup, 8'h00);
    hwStandby <= 1'b0;
    xfer(0, IDX_ADDR_PULL, 0);
    chk(q, RST_PORT);
    xfer(0, IDX_ADDR_PIN, 0);
    chk(q, extA);
    $display("standby test done");
  endtask
  initial begin
    t_regs();
    t_modes();
    t_stby();
    summarize();
  end
endmodule
`default_nettype wire
